// File: rtl/exec_slice_regs.vh
// Constants for the add, and, branch and bit-clear execution slice.
`ifndef EXEC_SLICE_REGS_VH
`define EXEC_SLICE_REGS_VH
`define OPC6_ADD_CARRY     6'h08
`define OPC6_AND_FILE      6'h05
`define OPC8_AND_LIT       8'h0B
`define OPC8_BRANCH_CARRY  8'hE2
`define OPC4_CLEAR_BIT     4'h9
`define IDX_LIMIT          8'h5F
`define FLAG_C             0
`define FLAG_DC            1
`define FLAG_Z             2
`define FLAG_OV            3
`define FLAG_N             4
`define Q1                 2'h0
`define Q2                 2'h1
`define Q3                 2'h2
`define Q4                 2'h3
`define STATUS_RESET       5'h00
`define WREG_RESET         8'h00
`define PC_RESET           21'h00_0000
`endif

// File: rtl/quarter_phase_gen.v
// Four-quarter phase sequencer for one instruction cycle.
`timescale 1ns/10ps
`default_nettype none
`include "exec_slice_regs.vh"
module quarter_phase_gen (
  input  wire       i_sys_clk,
  input  wire       i_rst,
  output reg  [1:0] o_quarter,
  output wire       o_cycle_end
);
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_quarter <= `Q1;
    end else begin
      o_quarter <= o_quarter + 2'h1;
    end
  end
  assign o_cycle_end = (o_quarter == `Q4);
endmodule
`default_nettype wire

// File: rtl/exec_slice.v
// Execution slice: add with carry, and, branch on carry, bit clear.
//
// Function
// (RULE1) Add-with-carry-to-file sums working register, file operand and carry; opcode 0010 00da.
// (RULE2) Add-with-carry updates negative, overflow, carry, digit carry and zero flags.
// (RULE3) Destination bit 0 writes working register; 1 writes the file register.
// (RULE4) Access bit 0 selects access bank; 1 uses bank select register.
// (RULE5) Extended set, access 0, address up to 95: indexed literal offset mode.
// (RULE6) AND-literal 0000 1011 ANDs working register with literal; flags N and Z.
// (RULE7) AND-with-file 0001 01da ANDs working register with file; flags N and Z.
// (RULE8) Branch-on-carry 1110 0010 branches only when carry is one; flags untouched.
// (RULE9) Offset is signed -128..127; target is incremented counter plus twice offset.
// (RULE10) Taken branch spends two cycles; counter written in Q4, second cycle idle.
// (RULE11) Untaken branch takes one cycle and writes nothing in Q4.
// (RULE12) Bit-clear 1001 bbba clears bit b of the file register; flags untouched.
// (RULE13) Literal instructions: decode, read literal, process, write working register.
// (RULE14) File instructions read in Q2 and write the destination in Q4.
//
// Added by the designer: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "exec_slice_regs.vh"
module exec_slice (
  input  wire        i_sys_clk,
  input  wire        i_rst,
  input  wire [15:0] i_instr,
  input  wire        i_ext_set_en,
  input  wire [3:0]  i_bank_select_register,
  input  wire [11:0] i_fsr2,
  input  wire [7:0]  i_file_rdata,
  output wire [1:0]  o_quarter,
  output reg  [11:0] o_file_addr,
  output reg         o_file_rd,
  output reg         o_file_wr,
  output reg  [7:0]  o_file_wdata,
  output reg  [7:0]  o_wreg,
  output reg  [4:0]  o_status,
  output reg  [20:0] o_pc,
  output reg         o_pc_wr,
  output reg         o_busy_nop,
  output reg         o_illegal
);
  localparam OP_NONE = 3'h0;
  localparam OP_ADDC = 3'h1;
  localparam OP_ANDL = 3'h2;
  localparam OP_ANDF = 3'h3;
  localparam OP_BC   = 3'h4;
  localparam OP_BCLR = 3'h5;

  wire        cycle_end;
  reg  [2:0]  op;
  reg  [15:0] ir;
  reg  [7:0]  operand;
  reg  [7:0]  result;
  reg  [4:0]  next_status;
  reg         nop_cycle;
  reg         write_wreg;
  reg         write_file;
  reg  [11:0] next_addr;
  reg  [8:0]  sum;
  reg  [4:0]  low_sum;
  reg  [7:0]  clr_mask;
  wire        dest_bit   = ir[9];
  wire        access_bit = ir[8];
  wire [7:0]  faddr      = ir[7:0];
  wire [20:0] offset_x2  = {{12{ir[7]}}, ir[7:0], 1'b0};

  quarter_phase_gen u_phase (
    .i_sys_clk   (i_sys_clk),
    .i_rst       (i_rst),
    .o_quarter   (o_quarter),
    .o_cycle_end (cycle_end)
  );

  // Opcode decode of the latched instruction word.
  always @* begin
    op = OP_NONE;
    if (ir[15:10] == `OPC6_ADD_CARRY) begin
      op = OP_ADDC; // RULE1
    end else if (ir[15:8] == `OPC8_AND_LIT) begin
      op = OP_ANDL; // RULE6
    end else if (ir[15:10] == `OPC6_AND_FILE) begin
      op = OP_ANDF; // RULE7
    end else if (ir[15:8] == `OPC8_BRANCH_CARRY) begin
      op = OP_BC; // RULE8
    end else if (ir[15:12] == `OPC4_CLEAR_BIT) begin
      op = OP_BCLR; // RULE12
    end
  end

  // File address formation from access bit and bank select.
  always @* begin
    if (!access_bit && i_ext_set_en && (faddr <= `IDX_LIMIT)) begin
      next_addr = i_fsr2 + {4'h0, faddr}; // RULE5
    end else if (!access_bit) begin
      next_addr = (faddr[7]) ? {4'hF, faddr} : {4'h0, faddr}; // RULE4
    end else begin
      next_addr = {i_bank_select_register, faddr}; // RULE4
    end
  end

  // Arithmetic and logic for add, and and bit clear.
  always @* begin
    next_status = o_status;
    result      = 8'h00;
    write_wreg  = 1'b0;
    write_file  = 1'b0;
    clr_mask    = 8'hFF;
    clr_mask[ir[11:9]] = 1'b0;
    sum     = {1'b0, o_wreg} + {1'b0, operand} + {8'h00, o_status[`FLAG_C]}; // RULE1
    low_sum = {1'b0, o_wreg[3:0]} + {1'b0, operand[3:0]} + {4'h0, o_status[`FLAG_C]};
    case (op)
      OP_ADDC: begin
        result = sum[7:0];
        next_status[`FLAG_C]  = sum[8]; // RULE2
        next_status[`FLAG_DC] = low_sum[4];
        next_status[`FLAG_OV] = (o_wreg[7] == operand[7]) && (result[7] != o_wreg[7]);
        next_status[`FLAG_N]  = result[7];
        next_status[`FLAG_Z]  = (result == 8'h00);
        write_wreg = !dest_bit; // RULE3
        write_file = dest_bit;
      end
      OP_ANDL: begin
        result = o_wreg & ir[7:0]; // RULE6
        next_status[`FLAG_N] = result[7];
        next_status[`FLAG_Z] = (result == 8'h00);
        write_wreg = 1'b1; // RULE13
      end
      OP_ANDF: begin
        result = o_wreg & operand; // RULE7
        next_status[`FLAG_N] = result[7];
        next_status[`FLAG_Z] = (result == 8'h00);
        write_wreg = !dest_bit; // RULE3
        write_file = dest_bit;
      end
      OP_BCLR: begin
        result = operand & clr_mask; // RULE12
        write_file = 1'b1;
      end
      default: begin
        result = 8'h00;
      end
    endcase
  end

  // Quarter-phase sequencing. The second cycle of a taken branch is a
  // flushed slot, so its instruction word is ignored entirely.
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      ir           <= 16'h0000;
      operand      <= 8'h00;
      o_wreg       <= `WREG_RESET;
      o_status     <= `STATUS_RESET;
      o_pc         <= `PC_RESET;
      o_pc_wr      <= 1'b0;
      o_file_addr  <= 12'h000;
      o_file_rd    <= 1'b0;
      o_file_wr    <= 1'b0;
      o_file_wdata <= 8'h00;
      o_busy_nop   <= 1'b0;
      o_illegal    <= 1'b0;
      nop_cycle    <= 1'b0;
    end else begin
      o_file_rd <= 1'b0;
      o_file_wr <= 1'b0;
      o_pc_wr   <= 1'b0;
      case (o_quarter)
        `Q1: begin
          o_busy_nop <= nop_cycle;
          if (nop_cycle) begin
            ir <= 16'h0000; // RULE10
          end else begin
            ir <= i_instr;
          end
        end
        `Q2: begin
          o_illegal <= (op == OP_NONE) && !nop_cycle;
          if ((op == OP_ADDC) || (op == OP_ANDF) || (op == OP_BCLR)) begin
            o_file_addr <= next_addr;
            o_file_rd   <= 1'b1; // RULE14
          end
        end
        `Q3: begin
          operand <= i_file_rdata; // RULE14
        end
        `Q4: begin
          nop_cycle <= 1'b0;
          if (!nop_cycle) begin
            o_pc <= o_pc + 21'h00_0002;
          end
          if (op == OP_BC && o_status[`FLAG_C]) begin
            o_pc      <= o_pc + 21'h00_0002 + offset_x2; // RULE9
            o_pc_wr   <= 1'b1; // RULE10
            nop_cycle <= 1'b1; // RULE10
          end
          // An untaken branch simply falls through with no Q4 write. RULE11
          o_status <= next_status; // RULE8
          if (write_wreg) begin
            o_wreg <= result; // RULE3
          end
          if (write_file) begin
            o_file_wr    <= 1'b1; // RULE14
            o_file_wdata <= result;
          end
        end
        default: begin
          o_file_rd <= 1'b0;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// File: tb/file_mem_model.sv
// Data memory model that answers the slice's file reads and writes.
`timescale 1ns/10ps
`default_nettype none
module file_mem_model (
  input  wire logic        i_sys_clk,
  input  wire logic [11:0] i_addr,
  input  wire logic        i_rd,
  input  wire logic        i_wr,
  input  wire logic [7:0]  i_wdata,
  output var  logic [7:0]  o_rdata
);
  logic [7:0] mem [0:4095];
  initial begin
    for (int i = 0; i < 4096; i++) mem[i] = 8'((i * 37) ^ 90);
  end
  always @(posedge i_sys_clk) begin
    if (i_wr) mem[i_addr] <= i_wdata;
  end
  // The slice takes the data at the edge that ends its read pulse, so the answer is
  // combinational; outside a read the lines show inverted data, so a stray sample fails.
  always_comb o_rdata = i_rd ? mem[i_addr] : ~mem[i_addr];
endmodule
`default_nettype wire

// File: tb/exec_slice_checker.sv
// Port timing checker for the execution slice.
`timescale 1ns/10ps
`default_nettype none
module exec_slice_checker (
  input wire        i_sys_clk,
  input wire        i_rst,
  input wire [15:0] i_instr,
  input wire [1:0]  o_quarter,
  input wire        o_file_rd,
  input wire        o_file_wr,
  input wire [4:0]  o_status,
  input wire        o_pc_wr,
  input wire        o_busy_nop
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  // The idle slot after a taken branch starts with the counter write pulse still high.
  wire go = (o_quarter == 2'h0) && !o_pc_wr;
  wire bc = go && (i_instr[15:8] == 8'hE2);
  sequence s_idle; o_busy_nop [*4]; endsequence
  sequence s_no_pc; !o_pc_wr [*4]; endsequence
  property p_quarter; o_quarter != 2'h3 |=> o_quarter == $past(o_quarter) + 2'h1; endproperty
  property p_rd; o_file_rd |-> o_quarter == 2'h2; endproperty
  property p_wr; o_file_wr |-> o_quarter == 2'h0; endproperty
  property p_taken; bc && o_status[0] |-> ##4 o_pc_wr ##1 s_idle; endproperty
  property p_untaken; bc && !o_status[0] |-> ##1 s_no_pc; endproperty
  property p_bc_flags; bc |-> ##4 o_status == $past(o_status, 4); endproperty
  property p_clr_flags; go && i_instr[15:12] == 4'h9 |-> ##4 o_status == $past(o_status, 4);
  endproperty
  property p_and_flags; go && (i_instr[15:8] == 8'h0B || i_instr[15:10] == 6'h05)
    |-> ##4 (o_status & 5'h0B) == ($past(o_status, 4) & 5'h0B); endproperty
  property p_lit; go && i_instr[15:8] == 8'h0B |-> ##1 !o_file_rd [*4]; endproperty
  a_quarter: assert property (p_quarter) else $error("quarter out of step");
  a_rd: assert property (p_rd) else $error("file read off its quarter");
  a_wr: assert property (p_wr) else $error("file write off its quarter");
  a_taken: assert property (p_taken) else $error("taken branch timing");
  a_untaken: assert property (p_untaken) else $error("untaken branch wrote");
  a_bc_flags: assert property (p_bc_flags) else $error("branch moved flags");
  a_clr_flags: assert property (p_clr_flags) else $error("bit clear moved flags");
  a_and_flags: assert property (p_and_flags) else $error("and moved flags");
  a_lit: assert property (p_lit) else $error("literal read a file");
endmodule
bind exec_slice exec_slice_checker u_chk (.i_sys_clk, .i_rst, .i_instr, .o_quarter,
  .o_file_rd, .o_file_wr, .o_status, .o_pc_wr, .o_busy_nop);
`default_nettype wire

// File: tb/tb.sv
// Self-checking bench for the execution slice against a reference model.
`timescale 1ns/10ps
`default_nettype none
module tb;
  typedef struct {int w, s, p, a, m, n, l;} res_t;
  logic        i_sys_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic        i_ext_set_en = 1'b0;
  logic [15:0] i_instr = 16'h0000;
  logic [3:0]  i_bank_select_register = 4'h0;
  logic [11:0] i_fsr2 = 12'h000;
  wire  [7:0]  i_file_rdata, o_file_wdata, o_wreg;
  wire  [11:0] o_file_addr;
  wire  [4:0]  o_status;
  wire  [20:0] o_pc;
  wire  [1:0]  o_quarter;
  wire         o_file_rd, o_file_wr, o_busy_nop, o_illegal;
  int          w, st, pc, skip, cyc, n_mismatch, checks, m[4096];
  int          base[6] = '{8192, 2816, 5120, 57856, 36864, 65535};
  int          msk[6] = '{1023, 255, 1023, 255, 4095, 0};
  res_t        q[$];
  exec_slice u_exec_slice (.i_sys_clk, .i_rst, .i_instr, .i_ext_set_en, .i_bank_select_register,
    .i_fsr2, .i_file_rdata, .o_quarter, .o_file_addr, .o_file_rd, .o_file_wr, .o_file_wdata,
    .o_wreg, .o_status, .o_pc, .o_pc_wr(), .o_busy_nop, .o_illegal);
  file_mem_model u_mem (.i_sys_clk, .i_addr(o_file_addr), .i_rd(o_file_rd), .i_wr(o_file_wr),
    .i_wdata(o_file_wdata), .o_rdata(i_file_rdata));
  initial forever #5 i_sys_clk = ~i_sys_clk;
  task automatic chk(input logic [20:0] seen, input int exp);
    checks++;
    if (seen !== 21'(exp)) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, 21'(exp));
    end
  endtask
  task close_out;
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  function automatic int ea(int f, int a, int x);
    if (a) return (x >> 12 & 15) * 256 + f;
    if (x[16] && f <= 95) return (x + f) & 4095;
    return f < 128 ? f : 3840 + f;
  endfunction
  task automatic issue(input int ins, input int x);
    int f, d, dst, v, s, tk, il;
    f = ins & 255;
    d = ins >> 9 & 1;
    dst = ea(f, ins >> 8 & 1, x);
    v = m[dst];
    tk = 0;
    il = !skip && !(ins >> 10 == 8 || ins >> 8 == 11 || ins >> 10 == 5 || ins >> 8 == 226
      || ins >> 12 == 9);
    // The idle slot does not advance the counter: it already holds the target.
    if (skip) begin
      skip = 0;
      pc -= 2;
    end
    else if (ins >> 10 == 8) begin
      s = w + v + (st & 1);
      st = (s > 255) | ((w % 16 + v % 16 + (st & 1) > 15) << 1) | ((s % 256 == 0) << 2)
        | (((w ^ s) & (v ^ s) & 128) >> 4) | ((s & 128) >> 3);
      if (d) m[dst] = s % 256;
      else w = s % 256;
    end else if (ins >> 8 == 11 || ins >> 10 == 5) begin
      s = w & (ins >> 8 == 11 ? f : v);
      st = (st & 11) | ((s == 0) << 2) | ((s & 128) >> 3);
      if (ins >> 8 == 11 || !d) w = s;
      else m[dst] = s;
    end else if (ins >> 8 == 226 && st % 2) begin
      tk = 1;
      skip = 1;
      pc += 2 * $signed(8'(f));
    end else if (ins >> 12 == 9) m[dst] &= ~(1 << (ins >> 9 & 7));
    pc = (pc + 2) & 21'h1F_FFFF;
    i_instr <= 16'(ins);
    i_ext_set_en <= x[16];
    i_bank_select_register <= 4'(x >> 12);
    i_fsr2 <= 12'(x);
    repeat (4) @(posedge i_sys_clk);
    q.push_back('{w, st, pc, dst, m[dst], tk, il});
  endtask
  always @(negedge i_sys_clk) begin
    res_t r;
    if (o_quarter === 2'h1 && q.size() > 0) begin
      r = q.pop_front();
      chk(o_wreg, r.w);
      chk(o_status, r.s);
      chk(o_pc, r.p);
      chk(u_mem.mem[r.a], r.m);
      chk(o_busy_nop, r.n);
      chk(o_illegal, r.l);
    end
  end
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_mismatch++;
      close_out;
    end
  end
  initial begin
    for (int i = 0; i < 4096; i++) m[i] = ((i * 37) ^ 90) & 255;
    void'($urandom(8453));
    repeat (8) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    // Every kind of instruction, an unknown word included, with random operands.
    for (int k = 0; k < 300; k++) issue(base[k % 6] | ($urandom & msk[k % 6]), $urandom);
    repeat (8) @(posedge i_sys_clk);
    close_out;
  end
endmodule
`default_nettype wire
